// >>> rtl/tpf_map.vh
/*
 tpf_map.vh: constants for the transaction-aware event filter.
 assumes plain verilog-2005 includers; definitions only.
*/
`ifndef TPF_MAP_VH
`define TPF_MAP_VH
`define TPF_ADDR_W 4
`define TPF_A_SEL0 4'h0
`define TPF_A_SEL1 4'h1
`define TPF_A_SEL2 4'h2
`define TPF_A_SEL3 4'h3
`define TPF_A_CNT0 4'h4
`define TPF_A_CNT1 4'h5
`define TPF_A_CNT2 4'h6
`define TPF_A_CNT3 4'h7
`define TPF_A_ABT_LO 4'h8
`define TPF_A_ABT_HI 4'h9
`define TPF_A_EIP_LO 4'ha
`define TPF_A_EIP_HI 4'hb
`define TPF_A_RIP_LO 4'hc
`define TPF_A_RIP_HI 4'hd
`define TPF_A_CAP 4'he
`define TPF_A_REC 4'hf
`define TPF_SEL_EVT_LO 0
`define TPF_SEL_EVT_HI 7
`define TPF_SEL_UM_LO 8
`define TPF_SEL_UM_HI 15
`define TPF_SEL_SAMPLED_RECORD_FACILITY 16
`define TPF_SEL_EN 22
`define TPF_SEL_IN_TX 32
`define TPF_SEL_TXCP 33
`define TPF_SEL_RST 34'h000000000
`define TPF_CKPT_CTR 2
`define TPF_NCTR 4
`define TPF_EVT_ELISION_ABT 8'hc8
`define TPF_EVT_RESTR_ABT 8'hc9
`define TPF_UM_ABT 8'h04
`define TPF_CAP_LEAF 32'h00000007
`define TPF_CAP_HLE_BIT 4
`define TPF_CAP_RTM_BIT 11
`define TPF_REC_EIP_OFS 8'hb0
`define TPF_REC_ABT_OFS 8'hb8
`define TPF_REC_RIP_OFS 8'h08
`define TPF_ABT_HLE 32
`define TPF_ABT_RTM 33
`define TPF_ABT_INSN 34
`define TPF_ABT_NINSN 35
`define TPF_ABT_RETRY 36
`define TPF_ABT_CONFL 37
`define TPF_ABT_CAPW 38
`define TPF_ABT_CAPR 39
`define TPF_ABT_SUSP 40
`define TPF_CAUSE_W 7
`define TPF_MASK_NONE 8'h00
`define TPF_MASK_ABT 8'h03
`define TPF_MASK_ALL 8'hff
`define TPF_ZERO32 32'h00000000
`define TPF_ONE32 32'h00000001
`define TPF_ZERO64 64'h0000000000000000
`endif

// >>> rtl/tpf_filter.v
/*
 tpf_filter.v: transaction-aware filter for four event counters, with
 checkpoint restore on counter two and abort-information record capture.
 assumes the pipeline reports region entry, commit and abort as one-cycle
 pulses in the core clock domain, and that software obeys the filter
 programming limits (checkpoint only on counter two, tx bits only when
 the capability flags are set).
*/
// Decided for this implementation: the placing of the registers and the plain strobed port.
// How it works
// - transaction-only bit 32 counts events inside regions only
// - checkpoint bit 33 removes events of regions that later abort
// - capability leaf 7 reports restricted flag bit 11, elision bit 4
// - both bits clear: count committed and aborted region events
// - on abort, checkpointed counter returns to its region entry value
// - transaction-only: outside-region conditions are discarded
// - sampled event inside a region aborts region first, then records
// - abort events c8h/c9h umask 04h may produce sampled records
// - abort-event sample is processed after abort completes
// - a sample pending inside a region forces region abort
// - pending-at-abort or abort overflow: only b0h and b8h valid
// - record ip at 08h: after elision prefix or fallback start
// - elision restarts at region start; restricted goes to fallback
// - abort info bits 31:0 hold last region cycle count
// - bit 32 elision abort, bit 33 restricted abort
// - bit 34 abort tied to eventing ip, bit 35 maybe unrelated
// - bit 36 retry may succeed, bit 37 data conflict
// - bit 38 write capacity, bit 39 read capacity
// - bit 40 suspend region abort; bits 63:41 reserved zero
`timescale 1ns/100ps
`include "tpf_map.vh"
module tpf_filter #(
  parameter HAS_ELISION = 1'b1,
  parameter HAS_RESTRICTED = 1'b1,
  parameter HAS_SUSPEND = 1'b0
) (
  input wire clk,
  input wire sys_rst,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire [3:0] evt_pulse,
  input wire tx_begin,
  input wire tx_commit,
  input wire tx_abort,
  input wire tx_is_elision,
  input wire [`TPF_CAUSE_W-1:0] tx_abort_cause,
  input wire [63:0] tx_region_ip,
  input wire [63:0] tx_event_ip,
  output wire tx_abort_req,
  output reg [63:0] tx_resume_ip,
  output reg tx_resume_valid,
  output reg sample_valid,
  output reg [7:0] sample_valid_mask
);
  reg [33:0] sel_q [0:`TPF_NCTR-1];
  reg [31:0] cnt_q [0:`TPF_NCTR-1];
  reg [31:0] shadow_q;
  reg in_tx_q;
  reg elision_q;
  reg [31:0] tx_cyc_q;
  reg [63:0] abt_info_q;
  reg [63:0] eip_q;
  reg [63:0] rip_q;
  reg pend_q;
  reg post_abort_q;
  reg abt_ovf_q;
  reg [31:0] cap_leaf_q;
  integer i;

  // counts an event for counter k under the tx filters
  function ctr_qual;
    input [33:0] sel;
    input evt;
    input in_tx;
    begin
      ctr_qual = sel[`TPF_SEL_EN] & evt &
                 (~sel[`TPF_SEL_IN_TX] | in_tx);
    end
  endfunction

  function is_abort_evt;
    input [33:0] sel;
    begin
      is_abort_evt = (sel[`TPF_SEL_UM_HI:`TPF_SEL_UM_LO] == `TPF_UM_ABT) &&
        ((sel[`TPF_SEL_EVT_HI:`TPF_SEL_EVT_LO] == `TPF_EVT_ELISION_ABT) ||
         (sel[`TPF_SEL_EVT_HI:`TPF_SEL_EVT_LO] == `TPF_EVT_RESTR_ABT));
    end
  endfunction

  wire tx_ok = HAS_ELISION | HAS_RESTRICTED;
  wire [3:0] qual;
  wire [3:0] samp_req;
  wire [3:0] abt_samp;
  genvar g;
  generate
    for (g = 0; g < `TPF_NCTR; g = g + 1) begin : g_q
      assign qual[g] = ctr_qual(sel_q[g], evt_pulse[g], in_tx_q);
      assign samp_req[g] = qual[g] & sel_q[g][`TPF_SEL_SAMPLED_RECORD_FACILITY] &
                           ~is_abort_evt(sel_q[g]);
      assign abt_samp[g] = sel_q[g][`TPF_SEL_EN] &
                           sel_q[g][`TPF_SEL_SAMPLED_RECORD_FACILITY] & is_abort_evt(sel_q[g]);
    end
  endgenerate

  wire samp_in_tx = |samp_req & in_tx_q;
  assign tx_abort_req = samp_in_tx | (pend_q & in_tx_q);
  wire abort_now = in_tx_q & tx_abort;
  wire commit_now = in_tx_q & tx_commit;
  wire abt_evt_hit = abort_now & |abt_samp;

  always @(posedge clk) begin
    if (sys_rst) begin
      for (i = 0; i < `TPF_NCTR; i = i + 1) begin
        sel_q[i] <= `TPF_SEL_RST;
        cnt_q[i] <= `TPF_ZERO32;
      end
      shadow_q <= `TPF_ZERO32;
      in_tx_q <= 1'b0;
      elision_q <= 1'b0;
      tx_cyc_q <= `TPF_ZERO32;
      abt_info_q <= `TPF_ZERO64;
      eip_q <= `TPF_ZERO64;
      rip_q <= `TPF_ZERO64;
      pend_q <= 1'b0;
      post_abort_q <= 1'b0;
      abt_ovf_q <= 1'b0;
      cap_leaf_q <= `TPF_ZERO32;
      tx_resume_ip <= `TPF_ZERO64;
      tx_resume_valid <= 1'b0;
      sample_valid <= 1'b0;
      sample_valid_mask <= `TPF_MASK_NONE;
    end else begin
      tx_resume_valid <= 1'b0;
      sample_valid <= 1'b0;
      for (i = 0; i < `TPF_NCTR; i = i + 1) begin
        if (reg_wr && reg_addr == i[3:0])
          sel_q[i][31:0] <= reg_wdata;
        else if (reg_wr && reg_addr == `TPF_A_REC) begin
          // tx bits of select i live in bits 2i+1:2i; refused if no support
          sel_q[i][`TPF_SEL_IN_TX] <= tx_ok & reg_wdata[2*i];
          sel_q[i][`TPF_SEL_TXCP] <= tx_ok & reg_wdata[2*i+1] &
                                     (i == `TPF_CKPT_CTR);
        end
        if (reg_wr && reg_addr == (`TPF_A_CNT0 + i[3:0]))
          cnt_q[i] <= reg_wdata;
        else if (qual[i])
          cnt_q[i] <= cnt_q[i] + `TPF_ONE32;
      end
      if (abort_now && sel_q[`TPF_CKPT_CTR][`TPF_SEL_TXCP])
        cnt_q[`TPF_CKPT_CTR] <= shadow_q;
      if (tx_begin && !in_tx_q) begin
        shadow_q <= cnt_q[`TPF_CKPT_CTR];
        in_tx_q <= 1'b1;
        elision_q <= tx_is_elision;
        rip_q <= tx_region_ip;
        tx_cyc_q <= `TPF_ONE32;
      end else if (in_tx_q) begin
        tx_cyc_q <= tx_cyc_q + `TPF_ONE32;
      end
      if (commit_now || abort_now) begin
        in_tx_q <= 1'b0;
        // last region cycles
        // committed regions update the cycle count as well
        abt_info_q[31:0] <= tx_cyc_q;
      end
      // sample outside a region is recorded directly
      if (|samp_req && !in_tx_q) begin
        sample_valid <= 1'b1;
        sample_valid_mask <= `TPF_MASK_ALL;
        eip_q <= tx_event_ip;
      end else if (samp_in_tx) begin
        pend_q <= 1'b1;
        eip_q <= tx_event_ip;
      end
      if (abort_now) begin
        abt_info_q <= {23'h000000, HAS_SUSPEND & tx_abort_cause[6],
                       tx_abort_cause[5:0], ~elision_q, elision_q,
                       tx_cyc_q};
        tx_resume_ip <= rip_q;
        tx_resume_valid <= 1'b1;
        // a sample raised in the abort cycle itself must not be lost
        post_abort_q <= pend_q | samp_in_tx | abt_evt_hit;
        abt_ovf_q <= abt_evt_hit;
        pend_q <= 1'b0;
      end
      if (post_abort_q) begin
        post_abort_q <= 1'b0;
        sample_valid <= 1'b1;
        sample_valid_mask <= `TPF_MASK_ABT;
      end
      if (reg_wr && reg_addr == `TPF_A_CAP)
        cap_leaf_q <= reg_wdata;
    end
  end

  wire [31:0] cap_word = (cap_leaf_q == `TPF_CAP_LEAF) ?
    ({20'h00000, HAS_RESTRICTED[0], 6'h00, HAS_ELISION[0], 4'h0}) :
    `TPF_ZERO32;

  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= `TPF_ZERO32;
    end else if (reg_rd) begin
      case (reg_addr)
        `TPF_A_SEL0, `TPF_A_SEL1, `TPF_A_SEL2, `TPF_A_SEL3:
          reg_rdata <= sel_q[reg_addr[1:0]][31:0];
        `TPF_A_CNT0, `TPF_A_CNT1, `TPF_A_CNT2, `TPF_A_CNT3:
          reg_rdata <= cnt_q[reg_addr[1:0]];
        `TPF_A_ABT_LO: reg_rdata <= abt_info_q[31:0];
        `TPF_A_ABT_HI: reg_rdata <= abt_info_q[63:32];
        `TPF_A_EIP_LO: reg_rdata <= eip_q[31:0];
        `TPF_A_EIP_HI: reg_rdata <= eip_q[63:32];
        `TPF_A_RIP_LO: reg_rdata <= rip_q[31:0];
        `TPF_A_RIP_HI: reg_rdata <= rip_q[63:32];
        `TPF_A_CAP: reg_rdata <= cap_word;
        `TPF_A_REC: reg_rdata <= {24'h000000,
          sel_q[3][33], sel_q[3][32], sel_q[2][33], sel_q[2][32],
          sel_q[1][33], sel_q[1][32], sel_q[0][33], sel_q[0][32]};
        default: reg_rdata <= `TPF_ZERO32;
      endcase
    end else begin
      reg_rdata <= `TPF_ZERO32;
    end
  end
endmodule // tpf_filter

// >>> tb/tpf_filter_sva.sv
/* checker for tpf_filter: abort, resume and sample timing.
 assumes a bind onto tpf_filter, one core clock, sync reset. */
`timescale 1ns/100ps
module tpf_filter_sva (
  input wire clk,
  input wire sys_rst,
  input wire [31:0] reg_rdata,
  input wire tx_begin,
  input wire tx_commit,
  input wire tx_abort,
  input wire [63:0] tx_region_ip,
  input wire tx_abort_req,
  input wire [63:0] tx_resume_ip,
  input wire tx_resume_valid,
  input wire sample_valid,
  input wire [7:0] sample_valid_mask
);
  reg in_q;
  reg [63:0] rip_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // own view of the region, so no design state is trusted
  always @(posedge clk) begin
    if (sys_rst)
      in_q <= 1'b0;
    else if (tx_begin && !in_q)
      in_q <= 1'b1;
    else if (tx_commit || tx_abort)
      in_q <= 1'b0;
    if (tx_begin && !in_q)
      rip_q <= tx_region_ip;
  end
  sequence s_abt;
    in_q && tx_abort;
  endsequence
  sequence s_pend_abt;
    s_abt ##0 tx_abort_req;
  endsequence
  AST_RESUME: assert property (s_abt |=> tx_resume_valid)
    else $error("no resume pulse after abort");
  AST_RESUME_SRC: assert property (tx_resume_valid |->
    $past(tx_abort) && $past(in_q))
    else $error("resume pulse without abort");
  AST_RESUME_ONE: assert property (tx_resume_valid |=> !tx_resume_valid)
    else $error("resume pulse too long");
  AST_RESUME_IP: assert property (tx_resume_valid |->
    tx_resume_ip == rip_q)
    else $error("resume target differs from region ip");
  AST_REQ_REGION: assert property (tx_abort_req |-> in_q)
    else $error("abort request outside region");
  AST_REQ_HOLD: assert property (tx_abort_req && !tx_abort && !tx_commit
    |=> tx_abort_req)
    else $error("abort request dropped before abort");
  AST_PEND_SAMPLE: assert property (s_pend_abt |->
    ##2 sample_valid && sample_valid_mask == 8'h03)
    else $error("pending sample not reported after abort");
  AST_MASK: assert property (sample_valid |->
    sample_valid_mask == 8'h03 || sample_valid_mask == 8'hff)
    else $error("bad sample mask");
  AST_RST: assert property ($fell(sys_rst) |->
    !tx_resume_valid && !sample_valid && reg_rdata == 32'h0)
    else $error("outputs not clear after reset");
endmodule // tpf_filter_sva
bind tpf_filter tpf_filter_sva tpf_filter_sva_inst (.clk(clk),
  .sys_rst(sys_rst), .reg_rdata(reg_rdata), .tx_begin(tx_begin),
  .tx_commit(tx_commit), .tx_abort(tx_abort), .tx_region_ip(tx_region_ip),
  .tx_abort_req(tx_abort_req), .tx_resume_ip(tx_resume_ip),
  .tx_resume_valid(tx_resume_valid), .sample_valid(sample_valid),
  .sample_valid_mask(sample_valid_mask));

// >>> tb/tpf_pipe_model.sv
/* pipeline model: region entry, commit and abort pulses.
 assumes the bench pulses start, finish and fail for one cycle. */
`timescale 1ns/100ps
module tpf_pipe_model (
  input wire clk,
  input wire sys_rst,
  input wire start,
  input wire finish,
  input wire fail,
  input wire tx_abort_req,
  output reg tx_begin,
  output reg tx_commit,
  output reg tx_abort
);
  reg in_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      in_q <= 1'b0;
      tx_begin <= 1'b0;
      tx_commit <= 1'b0;
      tx_abort <= 1'b0;
    end else begin
      tx_begin <= start && !in_q;
      tx_commit <= finish && in_q;
      tx_abort <= in_q && !tx_abort && (fail || tx_abort_req);
      if (tx_begin)
        in_q <= 1'b1;
      else if (tx_commit || tx_abort)
        in_q <= 1'b0;
    end
  end
endmodule // tpf_pipe_model

// >>> tb/tb_top.sv
/* self-checking bench for the transaction-aware event filter.
 assumes the pipeline model drives region pulses. */
`timescale 1ns/100ps
module tb_top;
  reg clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  reg start = 1'b0, finish = 1'b0, fail = 1'b0, tx_is_elision = 1'b0;
  reg [3:0] reg_addr = 4'h0, evt_pulse = 4'h0;
  reg [31:0] reg_wdata = 32'h0, d;
  reg [6:0] cause = 7'h0;
  reg [63:0] rip = 64'h0, eip = 64'h0;
  wire [63:0] tx_resume_ip;
  wire [31:0] reg_rdata;
  wire tx_begin, tx_commit, tx_abort, tx_abort_req, tx_resume_valid;
  wire sample_valid;
  wire [7:0] sample_valid_mask;
  integer miscompares = 0, n_compared = 0, k;
  always #5 clk = ~clk;
  tpf_filter tpf_filter_inst (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt_pulse(evt_pulse),
    .tx_begin(tx_begin), .tx_commit(tx_commit), .tx_abort(tx_abort),
    .tx_is_elision(tx_is_elision), .tx_abort_cause(cause),
    .tx_region_ip(rip), .tx_event_ip(eip), .tx_abort_req(tx_abort_req),
    .tx_resume_ip(tx_resume_ip), .tx_resume_valid(tx_resume_valid),
    .sample_valid(sample_valid), .sample_valid_mask(sample_valid_mask));
  tpf_pipe_model tpf_pipe_model_inst (.clk(clk), .sys_rst(sys_rst),
    .start(start), .finish(finish), .fail(fail),
    .tx_abort_req(tx_abort_req), .tx_begin(tx_begin),
    .tx_commit(tx_commit), .tx_abort(tx_abort));
  task results;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input [63:0] s, input [63:0] e);
    n_compared = n_compared + 1;
    if (s !== e) begin
      miscompares = miscompares + 1;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task wr(input [3:0] a, input [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // c: start, finish, fail
  task pp(input [2:0] c, input [3:0] e);
    @(posedge clk);
    {start, finish, fail} <= c;
    evt_pulse <= e;
    @(posedge clk);
    {start, finish, fail} <= 3'h0;
    evt_pulse <= 4'h0;
  endtask
  task wait_sv;
    integer i;
    #1;
    for (i = 0; i < 20 && sample_valid !== 1'b1; i = i + 1)
      @(posedge clk) #1;
    if (i == 20) begin
      miscompares = miscompares + 1;
      results;
    end
  endtask
  task t_cap;
    wr(4'he, 32'h7);
    rd(4'he);
    chk("cap", d, 32'h810);
  endtask
  task t_bits;
    wr(4'hf, 32'hff);
    rd(4'hf);
    chk("txbits", d, 32'h75);
  endtask
  task t_intx;
    wr(4'h0, 32'h00400000);
    wr(4'h4, 32'h0);
    wr(4'hf, 32'h1);
    pp(3'h0, 4'h1);
    pp(3'h4, 4'h0);
    pp(3'h0, 4'h1);
    pp(3'h0, 4'h1);
    pp(3'h2, 4'h0);
    rd(4'h4);
    chk("cnt0", d, 32'h2);
  endtask
  task t_ckpt;
    wr(4'h2, 32'h00400000);
    wr(4'hf, 32'h20);
    wr(4'h6, 32'h5);
    cause <= 7'h04;
    pp(3'h4, 4'h0);
    for (k = 0; k < 3; k = k + 1)
      pp(3'h0, 4'h4);
    pp(3'h1, 4'h0);
    rd(4'h6);
    chk("cnt2 abort", d, 32'h5);
    rd(4'h9);
    chk("abort hi", d, 32'h12);
    pp(3'h4, 4'h0);
    pp(3'h0, 4'h4);
    pp(3'h0, 4'h4);
    pp(3'h2, 4'h0);
    rd(4'h6);
    chk("cnt2 commit", d, 32'h7);
    rd(4'h8);
    chk("commit cycles", d, 32'h6);
  endtask
  task t_abtevt;
    for (k = 0; k < 2; k = k + 1) begin
      wr(4'h1, 32'h004104c8 + k);
      pp(3'h4, 4'h0);
      pp(3'h1, 4'h0);
      wait_sv;
      chk("abtevt mask", sample_valid_mask, 8'h03);
    end
    wr(4'h1, 32'h0);
  endtask
  task t_sample;
    wr(4'hf, 32'h0);
    wr(4'h0, 32'h00410000);
    tx_is_elision <= 1'b1;
    cause <= 7'h7f;
    rip <= 64'h12345678_9abcdef0;
    eip <= 64'h0fedcba9_87654321;
    pp(3'h4, 4'h0);
    pp(3'h0, 4'h1);
    wait_sv;
    chk("sample mask", sample_valid_mask, 8'h03);
    rd(4'h9);
    chk("abort hi", d, 32'hfd);
    rd(4'hc);
    chk("region ip", d, 32'h9abcdef0);
    rd(4'ha);
    chk("event ip", d, 32'h87654321);
    pp(3'h0, 4'h1);
    wait_sv;
    chk("plain mask", sample_valid_mask, 8'hff);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_cap;
    t_bits;
    t_intx;
    t_ckpt;
    t_abtevt;
    t_sample;
    results;
  end
endmodule // tb_top
